// ===== nfh_ctrl.sv
// NAND flash host controller: sequences commands, addresses and data
// Contract
// RULE_01: Array is 1024 blocks of 64 pages.
// RULE_02: Page holds 2K+64 bytes, or 1K+32 words.
// RULE_03: Erase acts on one whole block only.
// RULE_04: Page program busy typically 200 microseconds.
// RULE_05: Block erase busy typically 2 milliseconds.
// RULE_06: Array to buffer read at most 25us.
// RULE_07: Command, address, data share the IO pins.
// RULE_08: Host uses chip enable, write, latch strobes.
// RULE_09: Device runs program and erase on its own.
// RULE_10: Device refuses modify while lock is active.
// RULE_11: Device drives open-drain busy during operations.
// RULE_12: Wired busy lines show busy if any busy.
// RULE_13: Toggling chip enable must not abort reads.
// RULE_14: Copy-back reprograms held data into another page.
// RULE_15: Cache program accepts data while array writes.
// RULE_16: Cache buffer holds 2048 plus 64 bytes.
// RULE_17: Cache read streams consecutive pages back to back.
// RULE_18: Identification returns four bytes in fixed order.
// RULE_19: Host applies one-bit ECC per 528 bytes.
// RULE_20: Write strobe rise latches command or address.
// RULE_21: Output strobe fall outputs data, advances column.
// RULE_22: Four address cycles, unused second-cycle bits low.
// RULE_23: Low write-protect input locks program and erase.
// RULE_24: Busy from confirm until operation result ready.
`timescale 1ns/1ps
`default_nettype none
module nfh_ctrl #(
  parameter int PROG_CYC = nfh_pkg::PROG_CYC_DEF,
  parameter int ERASE_CYC = nfh_pkg::ERASE_CYC_DEF
) (
  input wire logic CLK_I,
  input wire logic NRST_I,
  input wire logic CMD_VALID_I,
  output logic CMD_READY_O,
  input wire nfh_pkg::nfh_req_t CMD_I,
  output logic DONE_O,
  output logic FAIL_O,
  output logic TIMEOUT_O,
  output logic ECC_SEG_O,
  input wire logic BUF_WE_I,
  input wire logic [nfh_pkg::COL_W-1:0] BUF_ADDR_I,
  input wire logic [7:0] BUF_WDATA_I,
  output logic [7:0] BUF_RDATA_O,
  output nfh_pkg::nfh_pins_t NAND_O,
  input wire logic [7:0] NAND_IO_I,
  input wire logic NAND_RB_I
);
  import nfh_pkg::*;

  typedef struct packed {
    nfh_state_t st;
    nfh_req_t req;
    logic [1:0] ph;
    logic [1:0] seq;
    logic [COL_W-1:0] idx;
    logic [CNT_W-1:0] cnt;
    logic [9:0] seg;
    logic seg_p;
    logic done;
    logic fail;
    logic tmo;
    nfh_pins_t pins;
  } nfh_regs_t;

  nfh_regs_t q, d;
  nfh_info_t info;
  nfh_info_t info_d;
  logic [7:0] mem_rd;
  logic [7:0] abyte;
  logic [COL_W-1:0] last_idx;
  logic [CNT_W-1:0] limit;
  logic beat_end;
  logic wr_beat;
  logic rd_beat;

  function automatic nfh_info_t op_info(input nfh_op_t op);
    nfh_info_t r;
    r = '0;
    r.a_last = 2'h3;
    r.has_addr = 1'b1;
    r.cmd1 = CMD_READ1;
    case (op)
      OP_READ, OP_CACHE_RD, OP_READ_CB: begin
        r.cmd2 = (op == OP_READ) ? CMD_READ_GO :
                 (op == OP_CACHE_RD) ? CMD_CACHE_RD : CMD_READ_CB;
        r.has_cmd2 = 1'b1;
        r.has_wait = 1'b1;
        r.has_r = (op != OP_READ_CB); // RULE_17
      end
      OP_READ_ID: begin
        r.cmd1 = CMD_READ_ID;
        r.a_last = 2'h0;
        r.has_r = 1'b1; // RULE_18
      end
      OP_PROG, OP_CACHE_PROG: begin
        r.cmd1 = CMD_PROG1;
        r.cmd2 = (op == OP_PROG) ? CMD_PROG_GO : CMD_CACHE_PROG; // RULE_15
        r.has_w = 1'b1;
        r.has_cmd2 = 1'b1;
        r.has_wait = 1'b1;
        r.has_stat = 1'b1;
        r.modify = 1'b1;
      end
      OP_CB_PROG: begin
        r.cmd1 = CMD_CB_PROG; // RULE_14
        r.cmd2 = CMD_PROG_GO;
        r.has_cmd2 = 1'b1;
        r.has_wait = 1'b1;
        r.has_stat = 1'b1;
        r.modify = 1'b1;
      end
      OP_ERASE: begin
        r.cmd1 = CMD_ERASE1;
        r.cmd2 = CMD_ERASE_GO;
        r.a_first = 2'h2; // RULE_03
        r.has_cmd2 = 1'b1;
        r.has_wait = 1'b1;
        r.has_stat = 1'b1;
        r.modify = 1'b1;
      end
      OP_CACHE_NEXT, OP_CACHE_EXIT, OP_RESET: begin
        r.cmd1 = (op == OP_RESET) ? CMD_RESET :
                 (op == OP_CACHE_NEXT) ? CMD_CACHE_RD : CMD_CACHE_EXIT;
        r.has_addr = 1'b0;
        r.has_wait = 1'b1;
        r.has_r = (op != OP_RESET);
      end
      default: begin
        r.has_addr = 1'b0;
      end
    endcase
    return r;
  endfunction

  nfh_page_mem u_mem (
    .CLK_I(CLK_I),
    .a_we_i(BUF_WE_I),
    .a_addr_i(BUF_ADDR_I),
    .a_wdata_i(BUF_WDATA_I),
    .a_rdata_o(BUF_RDATA_O),
    .b_we_i(q.st == ST_RDAT && q.ph == 2'h2),
    // Next index, so the registered read byte is ready at the beat start
    .b_addr_i(d.idx),
    .b_wdata_i(NAND_IO_I),
    .b_rdata_o(mem_rd)
  );

  always_comb begin
    info = op_info(q.req.op);
    case (q.seq)
      2'h0: abyte = (q.req.op == OP_READ_ID) ? 8'h00 : q.req.col[7:0];
      2'h1: abyte = {4'h0, q.req.col[11:8]}; // RULE_22
      2'h2: abyte = q.req.row[7:0];
      default: abyte = q.req.row[15:8];
    endcase
    last_idx = (q.req.op == OP_READ_ID) ? COL_W'(ID_LAST) :
               COL_W'(PAGE_LAST); // RULE_02
    case (q.req.op)
      OP_ERASE: limit = CNT_W'(ERASE_CYC * TMO_MULT); // RULE_05
      OP_READ, OP_READ_CB, OP_CACHE_RD, OP_CACHE_NEXT, OP_CACHE_EXIT:
        limit = CNT_W'(READ_CYC * TMO_MULT); // RULE_06
      default: limit = CNT_W'(PROG_CYC * TMO_MULT); // RULE_04
    endcase
    beat_end = (q.ph == 2'h3);
    d = q;
    d.done = 1'b0;
    d.seg_p = 1'b0;
    if (q.st inside {ST_CMD1, ST_ADDR, ST_WDAT, ST_CMD2, ST_SCMD, ST_RDAT,
                     ST_SRD}) begin
      d.ph = q.ph + 2'h1;
    end
    case (q.st)
      ST_IDLE: begin
        d.ph = 2'h0;
        if (CMD_VALID_I) begin
          d.req = CMD_I;
          d.st = ST_CMD1;
          d.fail = 1'b0;
          d.tmo = 1'b0;
          d.seg = '0;
          d.idx = (CMD_I.op == OP_READ_ID) ? '0 : CMD_I.col;
        end
      end
      ST_CMD1: begin
        if (beat_end) begin
          d.seq = info.a_first;
          d.st = info.has_addr ? ST_ADDR : ST_WAITB;
          d.cnt = '0;
        end
      end
      ST_ADDR: begin
        if (beat_end) begin
          d.seq = q.seq + 2'h1;
          if (q.seq == info.a_last) begin
            d.cnt = '0;
            if (info.has_w) begin
              d.st = ST_WDAT;
            end else if (info.has_cmd2) begin
              d.st = ST_CMD2;
            end else begin
              d.st = ST_RDAT;
            end
          end
        end
      end
      ST_WDAT, ST_RDAT: begin
        if (q.ph == 2'h3 && q.idx != last_idx) begin
          d.idx = q.idx + COL_W'(1); // RULE_21
        end
        if (beat_end) begin
          d.seg = (q.seg == 10'(ECC_SEG_LAST)) ? '0 : q.seg + 10'h1;
          d.seg_p = (q.seg == 10'(ECC_SEG_LAST)); // RULE_19
          if (q.idx == last_idx) begin
            d.st = (q.st == ST_WDAT) ? ST_CMD2 : ST_DONE;
          end
        end
      end
      ST_CMD2: begin
        if (beat_end) begin
          d.st = ST_WAITB;
          d.cnt = '0;
        end
      end
      ST_WAITB: begin
        d.ph = 2'h0;
        d.cnt = q.cnt + CNT_W'(1);
        // Busy is only valid a short settle time after the last strobe
        if (q.cnt >= CNT_W'(BUSY_SETTLE_CYC) && NAND_RB_I) begin // RULE_12
          d.idx = q.req.col;
          d.seg = '0;
          d.st = info.has_r ? ST_RDAT : info.has_stat ? ST_SCMD : ST_DONE;
        end else if (q.cnt >= limit) begin
          d.tmo = 1'b1;
          d.st = ST_DONE;
        end
      end
      ST_SCMD: begin
        if (beat_end) begin
          d.st = ST_SRD;
        end
      end
      ST_SRD: begin
        if (q.ph == 2'h2) begin
          d.fail = NAND_IO_I[STAT_FAIL_BIT];
        end
        if (beat_end) begin
          d.st = ST_DONE;
        end
      end
      ST_DONE: begin
        d.done = 1'b1;
        d.st = ST_IDLE;
        d.ph = 2'h0;
      end
      default: begin
        d.st = ST_IDLE;
      end
    endcase
    wr_beat = d.st inside {ST_CMD1, ST_ADDR, ST_WDAT, ST_CMD2, ST_SCMD};
    rd_beat = d.st inside {ST_RDAT, ST_SRD};
    // Bus value is set at phase 0 and held through the strobe rise
    if (q.ph == 2'h0) begin
      case (q.st)
        ST_CMD1: d.pins.io = info.cmd1;
        ST_ADDR: d.pins.io = abyte;
        ST_WDAT: d.pins.io = mem_rd;
        ST_CMD2: d.pins.io = info.cmd2;
        ST_SCMD: d.pins.io = CMD_STATUS;
        default: d.pins.io = q.pins.io;
      endcase
    end
    d.pins.io_oe = wr_beat; // RULE_07
    d.pins.cle = d.st inside {ST_CMD1, ST_CMD2, ST_SCMD};
    d.pins.ale = (d.st == ST_ADDR);
    d.pins.we_n = !(wr_beat && d.ph inside {2'h1, 2'h2}); // RULE_08
    d.pins.output_strobe_n = !(rd_beat && d.ph inside {2'h1, 2'h2});
    d.pins.ce_n = (d.st == ST_IDLE);
    info_d = op_info(d.req.op);
    d.pins.wp_n = (d.st != ST_IDLE) && info_d.modify;
  end

  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      q <= '0;
      q.st <= ST_IDLE;
      q.pins.ce_n <= 1'b1;
      q.pins.we_n <= 1'b1;
      q.pins.output_strobe_n <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign CMD_READY_O = (q.st == ST_IDLE);
  assign DONE_O = q.done;
  assign FAIL_O = q.fail;
  assign TIMEOUT_O = q.tmo;
  assign ECC_SEG_O = q.seg_p;
  assign NAND_O = q.pins;

  AST_LATCH_EXCL: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    !(NAND_O.cle && NAND_O.ale) && (NAND_O.we_n || NAND_O.output_strobe_n))
    else $error("latch enables or strobes overlap"); // RULE_07
  AST_IO_HELD: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    $rose(NAND_O.we_n) |-> $stable(NAND_O.io) && $past(NAND_O.io_oe))
    else $error("bus not held at write strobe rise"); // RULE_07
  AST_WE_FRAME: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    $fell(NAND_O.we_n) |-> (!NAND_O.we_n && !NAND_O.ce_n)[*2]
    ##1 (NAND_O.we_n && !NAND_O.ce_n))
    else $error("write strobe pulse malformed"); // RULE_08
  AST_ADDR2_LOW: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    (q.st == ST_ADDR && q.seq == 2'h1 && !NAND_O.we_n)
    |-> NAND_O.ale && NAND_O.io[7:4] == 4'h0)
    else $error("second address cycle upper bits not low"); // RULE_22
  AST_BUSY_HONOURED: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    (q.st == ST_WAITB && d.st != ST_WAITB && !d.tmo)
    |-> NAND_RB_I && q.cnt >= CNT_W'(BUSY_SETTLE_CYC))
    else $error("left busy wait while line busy"); // RULE_12
  AST_ECC_SPACING: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    ECC_SEG_O |=> !ECC_SEG_O [*3])
    else $error("segment pulses too close"); // RULE_19

endmodule
`default_nettype wire

// ===== nfh_pkg.sv
// Shared constants and types for the NAND flash host controller
package nfh_pkg;

  localparam int CLK_MHZ = 40;
  localparam int PAGE_BYTES = 2112;
  localparam int PAGES_PER_BLOCK = 64;
  localparam int BLOCKS = 1024;
  localparam int COL_W = 12;
  localparam int ROW_W = 16;
  localparam int PAGE_LAST = PAGE_BYTES - 1;
  localparam int ID_LAST = 3;
  localparam int ECC_SEG_BYTES = 528;
  localparam int ECC_SEG_LAST = ECC_SEG_BYTES - 1;

  localparam int READ_TIME_US = 25;
  localparam int PROG_TIME_US = 200;
  localparam int ERASE_TIME_MS = 2;
  localparam int BUSY_SETTLE_NS = 100;
  localparam int READ_CYC = READ_TIME_US * CLK_MHZ;
  localparam int PROG_CYC_DEF = PROG_TIME_US * CLK_MHZ;
  localparam int ERASE_CYC_DEF = ERASE_TIME_MS * 1000 * CLK_MHZ;
  localparam int BUSY_SETTLE_CYC = (BUSY_SETTLE_NS * CLK_MHZ + 999) / 1000;
  localparam int TMO_MULT = 4;
  localparam int CNT_W = 20;

  localparam logic [7:0] CMD_READ1 = 8'h00;
  localparam logic [7:0] CMD_READ_GO = 8'h30;
  localparam logic [7:0] CMD_READ_CB = 8'h35;
  localparam logic [7:0] CMD_READ_ID = 8'h90;
  localparam logic [7:0] CMD_RESET = 8'hff;
  localparam logic [7:0] CMD_PROG1 = 8'h80;
  localparam logic [7:0] CMD_PROG_GO = 8'h10;
  localparam logic [7:0] CMD_CB_PROG = 8'h85;
  localparam logic [7:0] CMD_ERASE1 = 8'h60;
  localparam logic [7:0] CMD_ERASE_GO = 8'hd0;
  localparam logic [7:0] CMD_STATUS = 8'h70;
  localparam logic [7:0] CMD_CACHE_PROG = 8'h15;
  localparam logic [7:0] CMD_CACHE_RD = 8'h31;
  localparam logic [7:0] CMD_CACHE_EXIT = 8'h34;
  localparam int STAT_FAIL_BIT = 0;

  typedef enum logic [3:0] {
    OP_READ = 4'h0,
    OP_READ_ID = 4'h1,
    OP_RESET = 4'h2,
    OP_PROG = 4'h3,
    OP_CACHE_PROG = 4'h4,
    OP_READ_CB = 4'h5,
    OP_CB_PROG = 4'h6,
    OP_ERASE = 4'h7,
    OP_CACHE_RD = 4'h8,
    OP_CACHE_NEXT = 4'h9,
    OP_CACHE_EXIT = 4'ha
  } nfh_op_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_CMD1 = 4'h1,
    ST_ADDR = 4'h3,
    ST_WDAT = 4'h7,
    ST_CMD2 = 4'h6,
    ST_WAITB = 4'h2,
    ST_RDAT = 4'ha,
    ST_SCMD = 4'hb,
    ST_SRD = 4'h9,
    ST_DONE = 4'h8
  } nfh_state_t;

  typedef struct packed {
    nfh_op_t op;
    logic [ROW_W-1:0] row;
    logic [COL_W-1:0] col;
  } nfh_req_t;

  typedef struct packed {
    logic ce_n;
    logic cle;
    logic ale;
    logic we_n;
    logic output_strobe_n;
    logic wp_n;
    logic io_oe;
    logic [7:0] io;
  } nfh_pins_t;

  typedef struct packed {
    logic [7:0] cmd1;
    logic [7:0] cmd2;
    logic has_addr;
    logic [1:0] a_first;
    logic [1:0] a_last;
    logic has_w;
    logic has_cmd2;
    logic has_wait;
    logic has_r;
    logic has_stat;
    logic modify;
  } nfh_info_t;

endpackage

// ===== nfh_page_mem.sv
// Two-port page buffer with registered read data
`timescale 1ns/1ps
`default_nettype none
module nfh_page_mem (
  input wire logic CLK_I,
  input wire logic a_we_i,
  input wire logic [nfh_pkg::COL_W-1:0] a_addr_i,
  input wire logic [7:0] a_wdata_i,
  output logic [7:0] a_rdata_o,
  input wire logic b_we_i,
  input wire logic [nfh_pkg::COL_W-1:0] b_addr_i,
  input wire logic [7:0] b_wdata_i,
  output logic [7:0] b_rdata_o
);
  import nfh_pkg::*;

  logic [7:0] mem [PAGE_BYTES];

  always_ff @(posedge CLK_I) begin
    if (a_we_i) begin
      mem[a_addr_i] <= a_wdata_i;
    end
    if (b_we_i) begin
      mem[b_addr_i] <= b_wdata_i;
    end
    a_rdata_o <= mem[a_addr_i];
    b_rdata_o <= mem[b_addr_i];
  end

endmodule
`default_nettype wire

// ===== nfh_dev_model.sv
// Behavioural NAND flash device seen by the host controller bench
`timescale 1ns/1ps
`default_nettype none
module nfh_dev_model #(
  parameter int PROG_NS = 1000,
  parameter int ERASE_NS = 2000,
  parameter int READ_NS = 1500,
  parameter logic [31:0] ID_CODE = 32'h11d3c45a // Arbitrary value
) (
  input wire nfh_pkg::nfh_pins_t pins_i,
  input wire logic wp_n_i,
  input wire logic slow_i,
  output logic [7:0] io_o,
  output logic rb_o
);
  import nfh_pkg::*;
  logic [7:0] mem [int];
  logic [7:0] pbuf [PAGE_BYTES];
  logic [7:0] adr [4];
  logic [7:0] dout;
  logic busy;
  logic fail;
  int na, col, c0, row, rmode;

  // Slow mode stretches busy 50 times, past the host's patience for program, erase and reset but not for reads
  task automatic hold(input int ns);
    busy = 1'b1;
    #(slow_i ? ns * 50 : ns);
    busy = 1'b0;
  endtask

  task automatic load();
    for (int i = 0; i < PAGE_BYTES; i++) begin
      int k;
      k = row * 4096 + i;
      pbuf[i] = mem.exists(k) ? mem[k] : 8'hff;
    end
    col = c0;
  endtask

  task automatic erase(input logic [15:0] r);
    for (int k = r[15:6] * 262144; k < (r[15:6] + 1) * 262144; k++) begin
      if (mem.exists(k)) mem.delete(k);
    end
  endtask

  always @(posedge pins_i.we_n) begin
    if (!pins_i.ce_n && pins_i.ale && na < 4) begin
      adr[na] = pins_i.io;
      na++;
      if (na == 2) begin
        c0 = {adr[1][3:0], adr[0]};
        col = c0;
      end
      if (na == 4) row = {adr[3], adr[2]};
    end else if (!pins_i.ce_n && pins_i.cle) begin
      na = 0;
      case (pins_i.io)
        8'h90: begin
          rmode = 1;
          col = 0;
        end
        8'h70: rmode = 2;
        8'h80: begin
          rmode = 0;
          foreach (pbuf[i]) pbuf[i] = 8'hff;
        end
        8'h30, 8'h35, 8'h34: begin
          load();
          rmode = 0;
          hold(READ_NS);
        end
        8'h31: begin
          load();
          row++;
          rmode = 0;
          hold(READ_NS);
        end
        8'h10, 8'h15: begin
          fail = !wp_n_i;
          if (wp_n_i) foreach (pbuf[i]) mem[row * 4096 + i] = pbuf[i];
          hold(PROG_NS);
        end
        8'hd0: begin
          fail = !wp_n_i;
          if (wp_n_i) erase({adr[1], adr[0]});
          hold(ERASE_NS);
        end
        8'hff: hold(500);
        default: rmode = 0;
      endcase
    end else if (!pins_i.ce_n && !pins_i.ale && col < PAGE_BYTES) begin
      pbuf[col] = pins_i.io;
      col++;
    end
  end

  always @(negedge pins_i.output_strobe_n) begin
    if (!pins_i.ce_n) begin
      if (rmode == 1) dout = ID_CODE[8 * col +: 8];
      else if (rmode == 2) dout = {wp_n_i, ~busy, 5'h00, fail};
      else dout = col < PAGE_BYTES ? pbuf[col] : 8'hff;
      col++;
    end
  end

  // Released bus shows the inverse so stale data cannot pass
  assign io_o = (!pins_i.ce_n && !pins_i.output_strobe_n) ? dout : ~dout;
  assign rb_o = ~busy;

  initial begin
    busy = 1'b0;
    fail = 1'b0;
    dout = 8'h00;
    na = 0;
    col = 0;
    c0 = 0;
    row = 0;
    rmode = 0;
  end
endmodule
`default_nettype wire

// ===== nfh_tb.sv
// Self-checking bench for the NAND flash host controller
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import nfh_pkg::*;
  localparam logic [31:0] ID = 32'h11d3c45a; // Arbitrary value
  localparam int LIMIT = 40000;
  localparam logic [15:0] R1 = 16'h0041, R2 = 16'h0080, R3 = 16'h00c5;
  localparam logic [15:0] R4 = 16'h0100, R5 = 16'h0101;
  logic clk, nrst, valid, bwe, wp_en, slow, rb_ext, dev_rb;
  logic ready, done, fail, tmo, ecc;
  logic [COL_W-1:0] badr;
  logic [7:0] bwd, brd, dev_io;
  nfh_req_t cmd;
  nfh_pins_t pins;
  int err_count = 0, samples_checked = 0, cyc = 0, ecc_cnt = 0;

  nfh_ctrl #(.PROG_CYC(50), .ERASE_CYC(100)) dut (
    .CLK_I(clk), .NRST_I(nrst), .CMD_VALID_I(valid), .CMD_READY_O(ready),
    .CMD_I(cmd), .DONE_O(done), .FAIL_O(fail), .TIMEOUT_O(tmo),
    .ECC_SEG_O(ecc), .BUF_WE_I(bwe), .BUF_ADDR_I(badr),
    .BUF_WDATA_I(bwd), .BUF_RDATA_O(brd), .NAND_O(pins),
    .NAND_IO_I(dev_io), .NAND_RB_I(dev_rb & rb_ext)
  );
  nfh_dev_model #(.ID_CODE(ID)) dev (
    .pins_i(pins), .wp_n_i(pins.wp_n & wp_en), .slow_i(slow),
    .io_o(dev_io), .rb_o(dev_rb)
  );

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc++;
    if (ecc === 1'b1) ecc_cnt++;
    if (cyc == LIMIT) begin
      err_count++;
      complete_run();
    end
  end

  function automatic logic [7:0] pat(input logic [15:0] r, input int c);
    return r[7:0] ^ c[7:0] ^ {c[11:8], r[11:8]};
  endfunction

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic fill(input logic [15:0] r, input int c0, input logic z);
    for (int c = c0; c < PAGE_BYTES; c++) begin
      @(negedge clk);
      bwe = 1'b1;
      badr = c[COL_W-1:0];
      bwd = z ? 8'h00 : pat(r, c);
    end
    @(negedge clk);
    bwe = 1'b0;
  endtask

  task automatic issue(input nfh_op_t o, input logic [15:0] r, input int c);
    @(negedge clk);
    cmd = '{o, r, c[COL_W-1:0]};
    valid = 1'b1;
    @(negedge clk);
    valid = 1'b0;
  endtask

  task automatic wait_done();
    int n;
    n = 0;
    while (done !== 1'b1 && n < 20000) begin
      @(negedge clk);
      n++;
    end
    check("done", done, 1'b1);
  endtask

  task automatic run(input nfh_op_t o, input logic [15:0] r, input int c);
    issue(o, r, c);
    wait_done();
  endtask

  // Clears the tail of the buffer first so old contents cannot match
  task automatic read_chk(input nfh_op_t o, input logic [15:0] r,
                          input logic [15:0] er, input logic e);
    fill(r, 2048, 1'b1);
    run(o, r, 2048);
    for (int c = 2048; c < PAGE_BYTES; c++) begin
      @(negedge clk);
      badr = c[COL_W-1:0];
      @(negedge clk);
      check("page byte", brd, e ? 8'hff : pat(er, c));
    end
  endtask

  task automatic t_id();
    run(OP_READ_ID, 16'h0000, 0);
    for (int i = 0; i < 4; i++) begin
      @(negedge clk);
      badr = i[COL_W-1:0];
      @(negedge clk);
      check("id byte", brd, ID[8 * i +: 8]);
    end
  endtask

  task automatic t_prog();
    fill(R1, 0, 1'b0);
    ecc_cnt = 0;
    run(OP_PROG, R1, 0);
    check("ecc marks", ecc_cnt, 4);
    check("fail", fail, 1'b0);
    read_chk(OP_READ, R1, R1, 1'b0);
  endtask

  task automatic t_erase();
    fill(R2, 2048, 1'b0);
    run(OP_PROG, R2, 2048);
    run(OP_ERASE, R1, 0);
    read_chk(OP_READ, R1, R1, 1'b1);
    read_chk(OP_READ, R2, R2, 1'b0);
  endtask

  task automatic t_lock();
    wp_en = 1'b0;
    fill(R3, 2048, 1'b0);
    run(OP_PROG, R3, 2048);
    check("fail", fail, 1'b1);
    wp_en = 1'b1;
    read_chk(OP_READ, R3, R3, 1'b1);
  endtask

  task automatic t_copy();
    run(OP_READ_CB, R2, 2048);
    run(OP_CB_PROG, R3, 2048);
    read_chk(OP_READ, R3, R2, 1'b0);
  endtask

  task automatic t_cache();
    fill(R4, 2048, 1'b0);
    run(OP_CACHE_PROG, R4, 2048);
    fill(R5, 2048, 1'b0);
    run(OP_PROG, R5, 2048);
    read_chk(OP_CACHE_RD, R4, R4, 1'b0);
    read_chk(OP_CACHE_NEXT, R4, R5, 1'b0);
    read_chk(OP_CACHE_EXIT, R4, R4, 1'b1);
  endtask

  task automatic t_busy();
    int early;
    early = 0;
    rb_ext = 1'b0;
    issue(OP_RESET, 16'h0000, 0);
    repeat (150) begin
      @(negedge clk);
      if (done === 1'b1) early++;
    end
    check("early done", early, 0);
    rb_ext = 1'b1;
    wait_done();
  endtask

  task automatic t_tmo();
    slow = 1'b1;
    run(OP_ERASE, R2, 0);
    check("timeout", tmo, 1'b1);
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    nrst = 1'b0;
    valid = 1'b0;
    cmd = '0;
    bwe = 1'b0;
    badr = '0;
    bwd = 8'h00;
    wp_en = 1'b1;
    slow = 1'b0;
    rb_ext = 1'b1;
    repeat (10) @(negedge clk);
    check("ready", ready, 1'b1);
    check("ce_n", pins.ce_n, 1'b1);
    check("wp_n", pins.wp_n, 1'b0);
    nrst = 1'b1;
    t_id();
    t_prog();
    t_erase();
    t_lock();
    t_copy();
    t_cache();
    t_busy();
    t_tmo();
    complete_run();
  end
endmodule
`default_nettype wire
